// ===== shared/ssrx_defines.svh
// ssrx_defines.svh: offsets, field positions, encodings and counts of
// the clock-synchronous serial unit. assumes inclusion by bare name.
`ifndef SSRX_DEFINES_SVH
`define SSRX_DEFINES_SVH

// register offsets on the plain register port
`define SSRX_A_CTRL 8'h00
`define SSRX_A_DATA 8'h04
`define SSRX_A_STAT 8'h08
`define SSRX_A_ISTAT 8'h0C
`define SSRX_A_IEN 8'h10
`define SSRX_A_ICLR 8'h14

// serial_control_reg fields
`define SSRX_CTRL_START 7
`define SSRX_CTRL_INH 6
`define SSRX_CTRL_MODE_HI 5
`define SSRX_CTRL_MODE_LO 4
`define SSRX_CTRL_CLK_HI 2

// serial_status_reg fields and fixed reserved bits
`define SSRX_ST_ACTIVE 3
`define SSRX_ST_SHIFT 2
`define SSRX_ST_RSVD 8'hF3

// transfer_mode_field and clock_select_field encodings
`define SSRX_M_TX 2'h0
`define SSRX_M_RX 2'h1
`define SSRX_M_TXRX 2'h2
`define SSRX_CK_EXT 3'h7

// interrupt bits: byte complete, transfer stopped
`define SSRX_IRQ_DONE 0
`define SSRX_IRQ_STOP 1
`define SSRX_NIRQ 2

// last bit index of a byte; internal half period is base shifted by select
`define SSRX_LAST_BIT 3'h7
`define SSRX_DIV_BASE 8'h02

`endif

// ===== shared/ssrx_pkg.sv
// ssrx_pkg: types of the clock-synchronous serial unit.
// assumes the defines header sits on the include path.
package ssrx_pkg;
`include "ssrx_defines.svh"

// transfer sequencer, gray coded along idle -> shift -> wait
typedef enum logic [1:0] {
    SSRX_IDLE = 2'b00,
    SSRX_SHIFT = 2'b01,
    SSRX_WAIT = 2'b11
} ssrx_state_t;

typedef struct packed {
    logic start;
    logic inhibit;
    logic [1:0] mode;
    logic [2:0] clksel;
} ssrx_ctrl_t;

// pins arriving from outside the clock domain
typedef struct packed {
    logic sck;
    logic si;
} ssrx_pins_t;

typedef struct packed {
    ssrx_state_t state;
    ssrx_ctrl_t ctrl;
    logic [7:0] dbuf;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [7:0] divcnt;
    logic active;
    logic rd_done;
    logic wr_done;
    logic sck;
    logic sck_oe;
    logic so;
    logic [`SSRX_NIRQ-1:0] irq_stat;
    logic [`SSRX_NIRQ-1:0] irq_en;
    logic irq;
    logic [7:0] rdata;
} ssrx_regs_t;

endpackage

// ===== src/ssrx_sync.sv
// ssrx_sync: two-flop synchronisers with edge detection, one per bit.
// assumes inputs asynchronous to clk_i; edges are seen two cycles late.
`timescale 1ns/10ps
`default_nettype none

module ssrx_sync #(
    parameter int W = 2
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } ssrx_sync_t;

    ssrx_sync_t s;
    ssrx_sync_t next_s;

    // refuse a width that leaves no bit to synchronise
    if (W < 1) begin : g_chk_w
        $error("ssrx_sync: W must be at least 1");
    end

    // s1 feeds only s2; edges compare s2 against s3
    always_comb begin
        next_s.s1 = d_i;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // per-bit edge detectors
    for (genvar i = 0; i < W; i++) begin : g_edge
        assign rise_o[i] = s.s2[i] & ~s.s3[i];
        assign fall_o[i] = ~s.s2[i] & s.s3[i];
    end
    assign q_o = s.s2;

endmodule // ssrx_sync

`default_nettype wire

// ===== src/ssrx_top.sv
// ssrx_top: clock-synchronous 8-bit serial unit, transmit, receive and
// transmit/receive modes, register port, serial pins and interrupt.
// assumes SCK_I/SI_I asynchronous; register port on MCLK_I.
//
// Notes on behaviour
// - with start set, shift serial input in, lsb first, on the serial clock
// - eight bits received move to the data buffer and raise the interrupt
// - internal clock, receive: clock stalls until buffer read
// - external clock, receive: shifts follow the pin clock, never stall
// - start cleared mid byte: finish byte into buffer, then drop active
// - inhibit set: abort at once, active drops, partial data invalid
// - buffer is cleared on mode change; software reads it first
// - transmit/receive: drive on falling, sample on rising, lsb first
// - transmit/receive: after eighth bit buffer loads, interrupt raised
// - internal clock, transmit/receive: stall until read and write done
// - output holds previous last bit until first falling clock
// - start cleared in transmit/receive: finish byte, then drop active
// - inhibit in transmit/receive aborts both directions immediately
// - two-bit mode field selects transmit, receive or both
// - clock select 111 takes pin clock, others drive seven internal rates
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module ssrx_top
    import ssrx_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE_O,
    input wire logic SI_I,
    output logic SO_O,
    output logic IRQ_O
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam ssrx_regs_t REGS_RST = '{state: SSRX_IDLE, sck: 1'b1,
        sck_oe: 1'b1, default: '0};

    ssrx_regs_t r;
    ssrx_regs_t next_r;
    ssrx_pins_t pins_q;
    ssrx_pins_t pins_rise;
    ssrx_pins_t pins_fall;
    logic ext;
    logic tick;
    logic ev_fall;
    logic ev_rise;
    logic serviced;
    logic [7:0] shifted;
    logic [7:0] term;
    logic [7:0] addr;

    // the decoder reads address bits 7:0, so narrower ports are refused
    if (ADDR_W < 8) begin : g_chk_addr
        $error("ssrx_top: ADDR_W must be at least 8");
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    ssrx_sync #(
        .W(2)
    ) u_sync (
        .clk_i(MCLK_I),
        .rst_b_i(RST_B_I),
        .ce_i(CE_I),
        .d_i({SCK_I, SI_I}),
        .q_o(pins_q),
        .rise_o(pins_rise),
        .fall_o(pins_fall)
    );

    // ------------------------------------------------------------------
    // serial clock edges
    // ------------------------------------------------------------------
    // internal edges come from the divider, external ones from the pin
    assign addr = ADDR_I[7:0];
    assign ext = (r.ctrl.clksel == `SSRX_CK_EXT);
    assign term = (`SSRX_DIV_BASE << r.ctrl.clksel) - 8'h01;
    assign tick = !ext && (r.state == SSRX_SHIFT) && (r.divcnt == term);
    assign ev_fall = (r.state == SSRX_SHIFT)
        && (ext ? pins_fall.sck : (tick && r.sck));
    assign ev_rise = (r.state == SSRX_SHIFT)
        && (ext ? pins_rise.sck : (tick && !r.sck));
    assign shifted = {pins_q.si, r.shreg[7:1]};
    assign serviced = (r.rd_done || r.ctrl.mode == `SSRX_M_TX)
        && (r.wr_done || r.ctrl.mode == `SSRX_M_RX);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // bus effects first, engine after, so hardware sets win over clears
    always_comb begin
        next_r = r;
        next_r.rdata = 8'h00;
        if (WR_I) begin
            case (addr)
                `SSRX_A_CTRL: begin
                    next_r.ctrl = ssrx_ctrl_t'({WDATA_I[7:4],
                        WDATA_I[`SSRX_CTRL_CLK_HI:0]});
                    if (WDATA_I[`SSRX_CTRL_MODE_HI:`SSRX_CTRL_MODE_LO]
                            != r.ctrl.mode) begin
                        next_r.dbuf = 8'h00;
                    end
                    if (WDATA_I[`SSRX_CTRL_START]
                            && !WDATA_I[`SSRX_CTRL_INH]
                            && r.state == SSRX_IDLE
                            && WDATA_I[`SSRX_CTRL_MODE_HI:`SSRX_CTRL_MODE_LO]
                            != 2'h3) begin
                        next_r.state = SSRX_SHIFT;
                        next_r.active = 1'b1;
                        next_r.bitcnt = 3'h0;
                        next_r.divcnt = 8'h00;
                        next_r.sck = 1'b1;
                    end
                end
                `SSRX_A_DATA: begin
                    next_r.dbuf = WDATA_I;
                    next_r.wr_done = 1'b1;
                end
                `SSRX_A_IEN: next_r.irq_en = WDATA_I[`SSRX_NIRQ-1:0];
                `SSRX_A_ICLR: next_r.irq_stat = r.irq_stat
                    & ~WDATA_I[`SSRX_NIRQ-1:0];
                default: ;
            endcase
        end
        if (RD_I) begin
            case (addr)
                `SSRX_A_CTRL: next_r.rdata = {r.ctrl.start, r.ctrl.inhibit,
                    r.ctrl.mode, 1'b0, r.ctrl.clksel};
                `SSRX_A_DATA: begin
                    next_r.rdata = r.dbuf;
                    next_r.rd_done = 1'b1;
                end
                `SSRX_A_STAT: begin
                    next_r.rdata = `SSRX_ST_RSVD;
                    next_r.rdata[`SSRX_ST_ACTIVE] = r.active;
                    next_r.rdata[`SSRX_ST_SHIFT] = (r.state == SSRX_SHIFT);
                end
                `SSRX_A_ISTAT: next_r.rdata = {6'h00, r.irq_stat};
                `SSRX_A_IEN: next_r.rdata = {6'h00, r.irq_en};
                default: next_r.rdata = 8'h00;
            endcase
        end
        // sequencer
        case (r.state)
            SSRX_SHIFT: begin
                if (!ext) begin
                    next_r.divcnt = tick ? 8'h00 : r.divcnt + 8'h01;
                    if (tick) begin
                        next_r.sck = !r.sck;
                    end
                end
                // drive on falling; first falling reloads from buffer
                if (ev_fall && r.ctrl.mode != `SSRX_M_RX) begin
                    if (r.bitcnt == 3'h0) begin
                        next_r.shreg = r.dbuf;
                        next_r.so = r.dbuf[0];
                    end else begin
                        next_r.so = r.shreg[0];
                    end
                end
                if (ev_rise) begin
                    next_r.shreg = shifted;
                    next_r.bitcnt = r.bitcnt + 3'h1;
                    if (r.bitcnt == `SSRX_LAST_BIT) begin
                        if (r.ctrl.mode != `SSRX_M_TX) begin
                            next_r.dbuf = shifted;
                        end
                        next_r.irq_stat[`SSRX_IRQ_DONE] = 1'b1;
                        next_r.rd_done = 1'b0;
                        next_r.wr_done = 1'b0;
                        if (!next_r.ctrl.start) begin
                            next_r.state = SSRX_IDLE;
                            next_r.active = 1'b0;
                            next_r.irq_stat[`SSRX_IRQ_STOP] = 1'b1;
                        end else if (!ext) begin
                            next_r.state = SSRX_WAIT;
                        end
                    end
                end
            end
            SSRX_WAIT: begin
                // clock parked high until software has serviced the buffer
                if (!next_r.ctrl.start) begin
                    next_r.state = SSRX_IDLE;
                    next_r.active = 1'b0;
                    next_r.irq_stat[`SSRX_IRQ_STOP] = 1'b1;
                end else if (serviced) begin
                    next_r.state = SSRX_SHIFT;
                    next_r.divcnt = 8'h00;
                end
            end
            default: ;
        endcase
        // inhibit overrides everything; buffer contents left undefined
        if (next_r.ctrl.inhibit && r.active) begin
            next_r.state = SSRX_IDLE;
            next_r.active = 1'b0;
            next_r.sck = 1'b1;
            next_r.bitcnt = 3'h0;
            next_r.irq_stat[`SSRX_IRQ_STOP] = 1'b1;
        end
        next_r.sck_oe = (next_r.ctrl.clksel != `SSRX_CK_EXT);
        next_r.irq = |(next_r.irq_stat & next_r.irq_en);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            r <= REGS_RST;
        end else if (CE_I) begin
            r <= next_r;
        end
    end

    // outputs straight from flops
    assign RDATA_O = r.rdata;
    assign SCK_O = r.sck;
    assign SCK_OE_O = r.sck_oe;
    assign SO_O = r.so;
    assign IRQ_O = r.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_byte_irq;
        @(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
        (ev_rise && r.bitcnt == 3'h7) |=> r.irq_stat[`SSRX_IRQ_DONE]
            && r.bitcnt == 3'h0;
    endproperty
    a_byte_irq: assert property (p_byte_irq)
        else $error("byte completion did not flag the interrupt");

    property p_rx_lsb;
        @(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
        ev_rise |=> r.shreg[7] == $past(pins_q.si);
    endproperty
    a_rx_lsb: assert property (p_rx_lsb)
        else $error("sampled bit not shifted in at the top");

    property p_wait_stall;
        @(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
        (r.state == SSRX_WAIT && !serviced && next_r.ctrl.start
            && !next_r.ctrl.inhibit) |=> r.state == SSRX_WAIT && r.sck;
    endproperty
    a_wait_stall: assert property (p_wait_stall)
        else $error("serial clock resumed before buffer serviced");

    property p_inhibit;
        @(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
        (WR_I && addr == `SSRX_A_CTRL && WDATA_I[`SSRX_CTRL_INH]
            && r.active) |=> !r.active && r.state == SSRX_IDLE;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("inhibit did not abort the transfer");

    property p_stop_after_byte;
        @(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
        (ev_rise && r.bitcnt == 3'h7 && !next_r.ctrl.start)
            |=> !r.active && r.state == SSRX_IDLE;
    endproperty
    a_stop_after_byte: assert property (p_stop_after_byte)
        else $error("active flag not cleared after final byte");

    property p_first_bit;
        @(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
        (ev_fall && r.bitcnt == 3'h0 && r.ctrl.mode != `SSRX_M_RX)
            |=> SO_O == $past(r.dbuf[0]);
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("first bit not driven from buffer lsb");

    property p_hold_last;
        @(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
        // the output may only move at a falling serial clock
        !ev_fall |=> $stable(SO_O);
    endproperty
    a_hold_last: assert property (p_hold_last)
        else $error("serial output moved away from a falling clock");

    property p_ext_no_stall;
        @(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
        (ext && r.state != SSRX_IDLE) |-> r.state != SSRX_WAIT;
    endproperty
    a_ext_no_stall: assert property (p_ext_no_stall)
        else $error("external clock mode entered a wait state");

    property p_idle_clock;
        @(posedge MCLK_I) disable iff (!RST_B_I || !CE_I)
        (r.state == SSRX_IDLE) |=> $stable(SCK_O) || r.state != SSRX_IDLE;
    endproperty
    a_idle_clock: assert property (p_idle_clock)
        else $error("serial clock toggled while idle");

    c_byte: cover property (@(posedge MCLK_I) ev_rise && r.bitcnt == 3'h7);
    c_wait: cover property (@(posedge MCLK_I) r.state == SSRX_WAIT
        ##1 r.state == SSRX_SHIFT);
    c_abort: cover property (@(posedge MCLK_I) $fell(r.active)
        && r.ctrl.inhibit);

endmodule // ssrx_top

`default_nettype wire

// ===== tb/ssrx_peer.sv
// ssrx_peer: serial peer, lsb first, drives on falling, samples on rising.
// assumes the bench resolves the clock pin and pulses go_i once per frame.
`timescale 1ns/10ps
`default_nettype none

module ssrx_peer (
    input wire logic sck_i,
    input wire logic so_i,
    input wire logic ext_i,
    input wire logic go_i,
    input wire logic [7:0] tx_i,
    output logic si_o,
    output logic sck_o,
    output logic [7:0] rx_o
);
    // -------------------------------------------------------------
    // frame engine
    // -------------------------------------------------------------
    logic [7:0] txs;
    int n;
    initial begin
        si_o = 1'b0;
        sck_o = 1'b1;
        rx_o = 8'h00;
        txs = 8'h00;
        n = 0;
    end
    // new frame; an external clock only runs inside a frame, idles high
    always @(posedge go_i) begin
        txs = tx_i;
        n = 0;
        if (ext_i) begin
            repeat (8) begin
                #62.5 sck_o = 1'b0;
                #62.5 sck_o = 1'b1;
            end
        end
    end
    // next bit goes out on the falling clock, lsb first
    always @(negedge sck_i) begin
        si_o <= txs[0];
        txs <= {1'b0, txs[7:1]};
    end
    // sample on the rising clock; the line is inverted after bit eight,
    // late enough that the unit's synchronised sample is not disturbed
    always @(posedge sck_i) begin
        rx_o <= {so_i, rx_o[7:1]};
        n <= n + 1;
        if (n == 7)
            si_o <= #50 ~si_o;
    end
endmodule // ssrx_peer
`default_nettype wire

// ===== tb/ssrx_top_bench.sv
// ssrx_top_bench: random and corner tests of the serial unit.
// assumes the package, defines header and peer model compile first.
`timescale 1ns/10ps
`default_nettype none
`include "ssrx_defines.svh"

module ssrx_top_bench;
    logic MCLK_I = 1'b0;
    logic RST_B_I = 1'b0;
    logic [7:0] ADDR_I = 8'h00;
    logic [7:0] WDATA_I = 8'h00;
    logic WR_I = 1'b0;
    logic RD_I = 1'b0;
    logic [7:0] RDATA_O;
    logic SCK_O, SCK_OE_O, SI_I, SO_O, IRQ_O, psck;
    logic ext = 1'b0;
    logic go = 1'b0;
    logic [7:0] prx, v, b0, b1, t0, t1;
    logic [7:0] ptx = 8'h00;
    logic [7:0] md [2] = '{8'h20, 8'h10};
    logic [2:0] sel;
    int seed = 40;
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    // clock pin level: the unit drives it unless the peer clocks it
    wire logic sck_pin = SCK_OE_O ? SCK_O : psck;

    always #5 MCLK_I = ~MCLK_I;

    ssrx_top u_dut (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .CE_I(1'b1),
        .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
        .RDATA_O(RDATA_O), .SCK_I(sck_pin), .SCK_O(SCK_O),
        .SCK_OE_O(SCK_OE_O), .SI_I(SI_I), .SO_O(SO_O), .IRQ_O(IRQ_O));
    ssrx_peer u_peer (.sck_i(sck_pin), .so_i(SO_O), .ext_i(ext),
        .go_i(go), .tx_i(ptx), .si_o(SI_I), .sck_o(psck), .rx_o(prx));

    // -------------------------------------------------------------
    // bus and check tasks
    // -------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // trailing idle edge keeps two strobes from landing in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge MCLK_I);
        WR_I <= 1'b0;
        @(posedge MCLK_I);
    endtask
    // read data stand only in the cycle after the strobe: take them there
    task automatic rd(input logic [7:0] a);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge MCLK_I);
        RD_I <= 1'b0;
        @(negedge MCLK_I);
        v = RDATA_O;
        @(posedge MCLK_I);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
        rd(a);
        chk(nm, e, v);
    endtask
    task automatic load(input logic [7:0] b);
        ptx <= b;
        go <= 1'b1;
        @(posedge MCLK_I);
        go <= 1'b0;
        @(posedge MCLK_I);
    endtask
    task automatic wirq();
        int i;
        i = 0;
        while (IRQ_O !== 1'b1 && i < 4000) begin
            @(posedge MCLK_I);
            i++;
        end
        #1 chk("irq", 8'h01, {7'h00, IRQ_O});
    endtask
    // the serial clock must not leave its high idle level for n cycles
    task automatic stall(input int n);
        logic f;
        f = 1'b0;
        repeat (n) begin
            @(posedge MCLK_I);
            #1 f = f | (SCK_O !== 1'b1);
        end
        chk("sck held", 8'h00, {7'h00, f});
    endtask
    // polling bounded: a byte at the slowest rate the bench picks, select 3, is 256 cycles
    task automatic poll();
        int i;
        i = 0;
        v = 8'hFF;
        while (v[`SSRX_ST_ACTIVE] !== 1'b0 && i < 300) begin
            rd(`SSRX_A_STAT);
            i++;
        end
        chk("active", 8'hF3, v);
    endtask
    task automatic tend(input string nm);
        $display("test %s over, mismatches %0d", nm, fail_count);
    endtask
    task automatic conclude();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the tests need
    always @(posedge MCLK_I) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            conclude();
        end
    end

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        sel = 3'(1 + ($unsigned($random(seed)) % 3));
        b0 = 8'($random(seed));
        b1 = 8'($random(seed));
        t0 = 8'($random(seed));
        t1 = 8'($random(seed));
        repeat (8) @(posedge MCLK_I);
        RST_B_I <= 1'b1;
        @(posedge MCLK_I);
        #1 chk("pins", 8'h03, {6'h00, SCK_O, SCK_OE_O});
        chk("irq idle", 8'h00, {7'h00, IRQ_O});
        rdc("status", `SSRX_A_STAT, 8'hF3);
        rdc("istat", `SSRX_A_ISTAT, 8'h00);
        rdc("unmapped", 8'h1C, 8'h00);
        tend("reset");
        // receive, internal clock; stop by clearing start mid byte
        wr(`SSRX_A_IEN, 8'h01);
        load(b0);
        wr(`SSRX_A_CTRL, 8'h90 | 8'(sel));
        wirq();
        stall(40);
        load(b1);
        rdc("rx byte", `SSRX_A_DATA, b0);
        wr(`SSRX_A_ICLR, 8'h03);
        wr(`SSRX_A_CTRL, 8'h10 | 8'(sel));
        poll();
        rdc("last byte", `SSRX_A_DATA, b1);
        rdc("istat", `SSRX_A_ISTAT, 8'h03);
        chk("irq on", 8'h01, {7'h00, IRQ_O});
        wr(`SSRX_A_IEN, 8'h00);
        #1 chk("irq masked", 8'h00, {7'h00, IRQ_O});
        wr(`SSRX_A_ICLR, 8'h03);
        rdc("istat clr", `SSRX_A_ISTAT, 8'h00);
        tend("receive");
        // transmit/receive, internal clock
        wr(`SSRX_A_CTRL, 8'h20 | 8'(sel));
        rdc("mode clear", `SSRX_A_DATA, 8'h00);
        wr(`SSRX_A_IEN, 8'h01);
        wr(`SSRX_A_DATA, t0);
        load(b0);
        wr(`SSRX_A_CTRL, 8'hA0 | 8'(sel));
        wirq();
        chk("peer rx", t0, prx);
        rdc("txrx byte", `SSRX_A_DATA, b0);
        stall(40);
        wr(`SSRX_A_ICLR, 8'h03);
        load(b1);
        wr(`SSRX_A_DATA, t1);
        wr(`SSRX_A_CTRL, 8'h20 | 8'(sel));
        poll();
        rdc("txrx last", `SSRX_A_DATA, b1);
        chk("peer rx", t1, prx);
        tend("txrx");
        // restart, then abort mid byte in both modes
        wr(`SSRX_A_DATA, t0);
        load(b0);
        foreach (md[i]) begin
            wr(`SSRX_A_CTRL, md[i] | 8'h80 | 8'(sel));
            #1 if (i == 0) chk("so hold", {7'h00, t1[7]}, {7'h00, SO_O});
            repeat (20) @(posedge MCLK_I);
            wr(`SSRX_A_CTRL, md[i] | 8'h40 | 8'(sel));
            rdc("aborted", `SSRX_A_STAT, 8'hF3);
            stall(40);
            wr(`SSRX_A_CTRL, md[i] | 8'(sel));
        end
        tend("abort");
        // transmit only, then the reserved mode
        wr(`SSRX_A_CTRL, 8'h00 | 8'(sel));
        wr(`SSRX_A_ICLR, 8'h03);
        wr(`SSRX_A_DATA, t1);
        wr(`SSRX_A_CTRL, 8'h80 | 8'(sel));
        wirq();
        chk("tx only", t1, prx);
        wr(`SSRX_A_CTRL, 8'h00 | 8'(sel));
        wr(`SSRX_A_CTRL, 8'hB0 | 8'(sel));
        rdc("reserved", `SSRX_A_STAT, 8'hF3);
        tend("modes");
        // receive on the peer's clock, two bytes without reading
        wr(`SSRX_A_ICLR, 8'h03);
        wr(`SSRX_A_CTRL, 8'h17);
        #1 chk("pin released", 8'h00, {7'h00, SCK_OE_O});
        ext <= 1'b1;
        wr(`SSRX_A_CTRL, 8'h97);
        load(b0);
        wirq();
        wr(`SSRX_A_ICLR, 8'h03);
        load(b1);
        wirq();
        rdc("no stall", `SSRX_A_DATA, b1);
        wr(`SSRX_A_CTRL, 8'h17);
        tend("external");
        conclude();
    end
endmodule // ssrx_top_bench
`default_nettype wire
